/* File: src/agr_regs.v */
// Gain/RTD configuration and fault mask registers with fault summary
// Assumes a decoded register port (index, write strobe, read strobe) on clock,
// and raw fault levels arriving asynchronously from the analog front end.
`timescale 1ns/1ps
`default_nettype none
`include "agr_map.vh"
module agr_regs
(
    // Clock and reset
    input  wire                    clock,
    input  wire                    rst_n,
    // Register port
    input  wire [`AGR_ADDR_W-1:0]  reg_index,
    input  wire                    reg_write,
    input  wire                    reg_read,
    input  wire [`AGR_DATA_W-1:0]  reg_wdata,
    output reg  [`AGR_DATA_W-1:0]  reg_rdata,
    // Raw faults, same positions as mask bits 11:6 and 2:1
    input  wire [11:0]             fault_raw,
    // Front-end controls
    output wire                    rtd_wiring_select,
    output wire [2:0]              compensation_current_code,
    output wire [2:0]              excitation_current_code,
    output wire [9:0]              compensation_microamps,
    output wire [9:0]              excitation_microamps,
    output wire                    rtd_currents_enabled,
    output wire                    external_reference_resistor_select,
    output wire [3:0]              channel_gain_code,
    // Fault reporting
    output wire                    front_end_fault_summary,
    output reg                     error_pin_n
);
    reg  [`AGR_DATA_W-1:0] config_reg;
    reg  [`AGR_DATA_W-1:0] mask_reg;
    reg  [`AGR_DATA_W-1:0] detail_reg;
    reg  [`AGR_DATA_W-1:0] sync1_reg;
    reg  [`AGR_DATA_W-1:0] sync2_reg;
    reg  [`AGR_DATA_W-1:0] detail_next;
    wire [`AGR_DATA_W-1:0] fault_live;
    wire [`AGR_DATA_W-1:0] unmasked;
    wire                   comp_on;
    wire                   exc_on;
    wire                   detail_rd;

    // Faults are asynchronous to clock; two flops before any logic
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg <= `AGR_RESET_DETAIL;
            sync2_reg <= `AGR_RESET_DETAIL;
        end
        else
        begin
            sync1_reg <= {4'h0, fault_raw} & `AGR_MASK_WMASK;
            sync2_reg <= sync1_reg;
        end
    end

    assign fault_live = sync2_reg;

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            config_reg <= `AGR_RESET_CONFIG;
            mask_reg   <= `AGR_RESET_MASK;
        end
        else if (reg_write)
        begin
            if (reg_index == `AGR_ADDR_CONFIG)
                config_reg <= reg_wdata & `AGR_CONFIG_WMASK;
            if (reg_index == `AGR_ADDR_MASK)
                mask_reg <= reg_wdata & `AGR_MASK_WMASK;
        end
    end

    assign unmasked = fault_live & ~mask_reg & `AGR_MASK_WMASK;
    assign front_end_fault_summary = |unmasked;

    // latch until read; a fault in the read cycle survives
    assign detail_rd = reg_read && (reg_index == `AGR_ADDR_DETAIL);
    always @*
    begin
        detail_next = detail_rd ? `AGR_RESET_DETAIL : detail_reg;
        detail_next = detail_next | fault_live;
        detail_next[`AGR_BIT_SUMMARY] = detail_next[`AGR_BIT_SUMMARY]
                                        | front_end_fault_summary;
    end

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            detail_reg  <= `AGR_RESET_DETAIL;
            error_pin_n <= 1'b1;
        end
        else
        begin
            detail_reg  <= detail_next;
            error_pin_n <= ~front_end_fault_summary;
        end
    end

    // Read data registered; unmapped indices return zero
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= `AGR_RESET_CONFIG;
        else if (reg_read)
        begin
            case (reg_index)
                `AGR_ADDR_CONFIG: reg_rdata <= config_reg;
                `AGR_ADDR_MASK:   reg_rdata <= mask_reg;
                `AGR_ADDR_DETAIL: reg_rdata <= detail_reg;
                default:          reg_rdata <= `AGR_RESET_CONFIG;
            endcase
        end
    end

    assign rtd_wiring_select = config_reg[`AGR_BIT_WIRING];
    assign compensation_current_code = config_reg[`AGR_COMP_HI:`AGR_COMP_LO];
    assign excitation_current_code   = config_reg[`AGR_EXC_HI:`AGR_EXC_LO];
    assign external_reference_resistor_select = config_reg[`AGR_BIT_EXTRES];
    assign channel_gain_code = config_reg[`AGR_GAIN_HI:`AGR_GAIN_LO];

    agr_current_decode u_comp
    (
        .code      (compensation_current_code),
        .microamps (compensation_microamps),
        .enabled   (comp_on)
    );

    agr_current_decode u_exc
    (
        .code      (excitation_current_code),
        .microamps (excitation_microamps),
        .enabled   (exc_on)
    );

    assign rtd_currents_enabled = comp_on | exc_on;
endmodule
`default_nettype wire

/* File: shared/agr_map.vh */
// Register map and field constants for the gain/RTD and fault mask bank
// Assumes 16-bit registers reached by a small register index over the device port
`ifndef AGR_MAP_VH
`define AGR_MAP_VH
`define AGR_ADDR_W          4
`define AGR_DATA_W          16
`define AGR_NFAULT          8
`define AGR_ADDR_CONFIG     4'h5
`define AGR_ADDR_MASK       4'h6
`define AGR_ADDR_DETAIL     4'h7
`define AGR_RESET_CONFIG    16'h0000
`define AGR_RESET_MASK      16'h0000
`define AGR_RESET_DETAIL    16'h0000
`define AGR_CONFIG_WMASK    16'hFFF0
`define AGR_MASK_WMASK      16'h0FC6
`define AGR_BIT_WIRING      15
`define AGR_COMP_HI         14
`define AGR_COMP_LO         12
`define AGR_EXC_HI          11
`define AGR_EXC_LO          9
`define AGR_BIT_EXTRES      8
`define AGR_GAIN_HI         7
`define AGR_GAIN_LO         4
`define AGR_BIT_SUMMARY     0
`define AGR_CODE_OFF        3'h0
`define AGR_UA_OFF          10'h000
`define AGR_UA_100          10'h064
`define AGR_UA_400          10'h190
`define AGR_UA_500          10'h1F4
`define AGR_UA_600          10'h258
`define AGR_UA_900          10'h384
`define AGR_UA_1000         10'h3E8
`endif

/* File: src/agr_current_decode.v */
// Decoder from a 3-bit RTD current code to the magnitude in microamps
// Pure combinational; used once for excitation and once for compensation
`timescale 1ns/1ps
`default_nettype none
`include "agr_map.vh"
module agr_current_decode
(
    // Code in
    input  wire [2:0] code,
    // Magnitude out
    output reg  [9:0] microamps,
    output wire       enabled
);
    always @*
    begin
        case (code)
            3'h0:    microamps = `AGR_UA_OFF;
            3'h1:    microamps = `AGR_UA_100;
            3'h2:    microamps = `AGR_UA_400;
            3'h3:    microamps = `AGR_UA_500;
            3'h4:    microamps = `AGR_UA_500;
            3'h5:    microamps = `AGR_UA_600;
            3'h6:    microamps = `AGR_UA_900;
            3'h7:    microamps = `AGR_UA_1000;
            default: microamps = `AGR_UA_OFF;
        endcase
    end

    assign enabled = (code != `AGR_CODE_OFF);
endmodule
`default_nettype wire

/* File: verification/agr_regs_chk.sv */
// Port checker for the gain/RTD and fault mask bank
// Assumes it is bound onto agr_regs; one clock domain
`timescale 1ns/1ps
`default_nettype none
module agr_regs_chk
(
    // Register port
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [3:0]  reg_index,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    // Controls and fault reporting
    input wire logic [3:0]  channel_gain_code,
    input wire logic        front_end_fault_summary,
    input wire logic        error_pin_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_wc; reg_write && reg_index == 4'h5; endsequence
    sequence s_rd(idx); reg_read && reg_index == idx; endsequence
    property p_gn; s_wc |=> channel_gain_code == $past(reg_wdata[7:4]); endproperty
    a_gn: assert property (p_gn) else $error("gain");
    property p_rg; s_rd(4'h5) |=> reg_rdata[7:4] == $past(channel_gain_code); endproperty
    a_rg: assert property (p_rg) else $error("gain read");
    property p_st; !(reg_write && reg_index == 4'h5) |=> $stable(channel_gain_code); endproperty
    a_st: assert property (p_st) else $error("gain held");
    property p_cr; s_rd(4'h5) |=> reg_rdata[3:0] == 4'h0; endproperty
    a_cr: assert property (p_cr) else $error("cfg rsv");
    property p_mr; s_rd(4'h6) |=> (reg_rdata & 16'hF039) == 16'h0000; endproperty
    a_mr: assert property (p_mr) else $error("mask rsv");
    property p_rz; s_rd(4'h3) |=> reg_rdata == 16'h0000; endproperty
    a_rz: assert property (p_rz) else $error("unmapped");
    // Pin lags the summary by one flop
    property p_pn; front_end_fault_summary |=> !error_pin_n; endproperty
    a_pn: assert property (p_pn) else $error("pin low");
    property p_pu; !front_end_fault_summary |=> error_pin_n; endproperty
    a_pu: assert property (p_pu) else $error("pin high");
endmodule
`default_nettype wire

/* File: verification/agr_host.sv */
// Host model: one strobed word per access on the register port
// Assumes the bench calls acc; signals change on falling edges only
`timescale 1ns/1ps
`default_nettype none
module agr_host
(
    // Register port
    input  wire logic        clock,
    output var  logic [3:0]  reg_index,
    output var  logic        reg_write,
    output var  logic        reg_read,
    output var  logic [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    initial {reg_index, reg_write, reg_read, reg_wdata} = 22'h000000;
    // Stale data is inverted so it never passes for a fresh word
    task acc(input logic w, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
        @(negedge clock);
        reg_index = a;
        reg_write = w;
        reg_read = !w;
        reg_wdata = d;
        @(negedge clock);
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = ~d;
        q = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Bench comparing the gain/RTD and fault mask bank with an integer model
// Assumes agr_regs driven through the agr_host model
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock = 0, rst_n = 0;
    logic [11:0] fault_raw = 0;
    logic [15:0] reg_rdata, reg_wdata, q;
    logic [3:0] reg_index, channel_gain_code;
    logic [2:0] compensation_current_code, excitation_current_code;
    logic [9:0] compensation_microamps, excitation_microamps;
    logic reg_write, reg_read, rtd_wiring_select, rtd_currents_enabled;
    logic external_reference_resistor_select, front_end_fault_summary, error_pin_n;
    int num_errors = 0, samples_checked = 0, seed = 23905, cyc = 0, c, b;
    int ua[8] = '{0, 100, 400, 500, 500, 600, 900, 1000};
    int flt[8] = '{11, 10, 9, 8, 7, 6, 2, 1};
    always #25 clock = ~clock;
    agr_host i_agr_host (.*);
    agr_regs i_agr_regs (.*);
    task chk(input logic [15:0] s, e);
        samples_checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clock)
        if (++cyc > 5000)
        begin
            num_errors++;
            give_verdict;
        end
    initial
    begin
        repeat (5) @(negedge clock);
        rst_n = 1;
        i_agr_host.acc(0, 5, 0, q);
        chk(q, 0);
        i_agr_host.acc(0, 6, 0, q);
        chk(q, 0);
        i_agr_host.acc(1, 6, 16'hFFFF, q);
        i_agr_host.acc(0, 6, 0, q);
        chk(q, 16'h0FC6);
        i_agr_host.acc(0, 3, 0, q);
        chk(q, 0);
        repeat (30)
        begin
            c = $random(seed);
            i_agr_host.acc(1, 5, c[15:0], q);
            i_agr_host.acc(0, 5, 0, q);
            chk(q, c[15:0] & 16'hFFF0);
            chk({rtd_wiring_select, external_reference_resistor_select, channel_gain_code},
                {c[15], c[8], c[7:4]});
            chk(compensation_microamps, ua[c[14:12]]);
            chk(excitation_microamps, ua[c[11:9]]);
            chk({compensation_current_code, excitation_current_code}, c[14:9]);
            chk(rtd_currents_enabled, c[14:9] != 6'h00);
            chk(external_reference_resistor_select, c[8]);
        end
        foreach (flt[i])
        begin
            b = flt[i];
            i_agr_host.acc(1, 6, ~(16'h1 << b), q);
            fault_raw = 12'h1 << b;
            repeat (4) @(negedge clock);
            chk({front_end_fault_summary, error_pin_n}, 2'b10);
            i_agr_host.acc(1, 6, 16'h1 << b, q);
            @(negedge clock);
            chk({front_end_fault_summary, error_pin_n}, 2'b01);
            fault_raw = 0;
            repeat (3) @(negedge clock);
            i_agr_host.acc(0, 7, 0, q);
            chk(q, (16'h1 << b) | 16'h1);
            i_agr_host.acc(0, 7, 0, q);
            chk(q, 0);
        end
        // Reserved fault positions must never reach the summary or detail bits
        i_agr_host.acc(1, 6, 0, q);
        fault_raw = 12'h039;
        repeat (4) @(negedge clock);
        chk({front_end_fault_summary, error_pin_n}, 2'b01);
        fault_raw = 0;
        i_agr_host.acc(0, 7, 0, q);
        chk(q, 0);
        // A one-cycle fault still latches
        fault_raw = 12'h080;
        @(negedge clock);
        fault_raw = 0;
        repeat (3) @(negedge clock);
        i_agr_host.acc(0, 7, 0, q);
        chk(q, 16'h0081);
        give_verdict;
    end
endmodule
bind agr_regs agr_regs_chk i_agr_regs_chk (.*);
`default_nettype wire
